// ---- src/patb_defines.vh ----
// Register offsets, field positions, reset values and selector codes for the trigger/brake block
`ifndef PATB_DEFINES_VH
`define PATB_DEFINES_VH
`define PATB_OFF_BRAKE_FLAGS 12'h0F4
`define PATB_OFF_TRIG_SEL 12'h0F8
`define PATB_OFF_INT_STATUS 12'h100
`define PATB_OFF_INT_MASK 12'h104
`define PATB_OFF_LOCK 12'h108
`define PATB_EDGE_LSB 0
`define PATB_LEVEL_LSB 8
`define PATB_NUM_CH 6
`define PATB_TRIG_SEL_RESET 32'h00000000
`define PATB_TRIG_SEL_MASK 32'h8F8F8F8F
`define PATB_SEL_ZERO 4'h0
`define PATB_SEL_PERIOD 4'h1
`define PATB_SEL_ZERO_PERIOD 4'h2
`define PATB_SEL_EVEN_UP 4'h3
`define PATB_SEL_EVEN_DOWN 4'h4
`define PATB_SEL_ODD_UP 4'h8
`define PATB_SEL_ODD_DOWN 4'h9
`define PATB_UNLOCK_KEY 32'h0000A5C3
`endif

// ---- src/patb_sync2.v ----
// Two-flop synchroniser for a vector of external levels
module patb_sync2 #(
    parameter WIDTH = 12
) (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [WIDTH-1:0] d_async,
    output wire [WIDTH-1:0] q_sync
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end
        else if (clk_en)
        begin
            meta_reg <= d_async;
            sync_reg <= meta_reg;
        end
    end

    assign q_sync = sync_reg;
endmodule // patb_sync2

// ---- src/patb_trig_sel.v ----
// Trigger event selector for one channel of a channel pair
`include "patb_defines.vh"
module patb_trig_sel (
    input wire enable,
    input wire [3:0] source,
    input wire even_zero,
    input wire even_period,
    input wire even_up_match,
    input wire even_down_match,
    input wire odd_up_match,
    input wire odd_down_match,
    output reg hit
);
    // Reserved codes give no trigger at all
    always @*
    begin
        hit = 1'b0;
        if (enable)
        begin
            case (source)
                `PATB_SEL_ZERO: hit = even_zero;
                `PATB_SEL_PERIOD: hit = even_period;
                `PATB_SEL_ZERO_PERIOD: hit = even_zero | even_period;
                `PATB_SEL_EVEN_UP: hit = even_up_match;
                `PATB_SEL_EVEN_DOWN: hit = even_down_match;
                `PATB_SEL_ODD_UP: hit = odd_up_match;
                `PATB_SEL_ODD_DOWN: hit = odd_down_match;
                default: hit = 1'b0;
            endcase
        end
    end
endmodule // patb_trig_sel

// ---- src/patb_top.v ----
// APB register block with brake interrupt flags and ADC trigger selection
//
// The implementer's own choice: the APB register port.
`include "patb_defines.vh"
// Operation
// - Each channel's level brake event sets its flag at bit 8 plus channel, cleared by writing 1.
// - Each channel's edge brake event sets its flag at bit channel, cleared by writing 1.
// - Clearing writes to brake flags are taken only while the register lock is open.
// - A brake flag reads 0 unless an event has come since it was last cleared.
// - Channels 0 to 3 each have an enable bit at 7, 15, 23, 31 that gates their triggers.
// - Each channel has a 4-bit source field, choosing among events of its own pair.
// - Codes 0, 1, 2 pick even zero point, even period point, or either.
// - Codes 3 and 4 pick even channel compare match counting up or down.
// - Codes 8 and 9 pick odd channel compare match counting up or down.
// - The trigger select register is read-write and resets to zero.
module patb_top (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [5:0] level_brake_event,
    input wire [5:0] edge_brake_event,
    input wire [1:0] zero_point,
    input wire [1:0] period_point,
    input wire [3:0] up_match,
    input wire [3:0] down_match,
    output reg adc_trigger,
    output reg irq
);
    // Software-visible register state
    reg [5:0] level_brake_flag_reg;
    reg [5:0] edge_brake_flag_reg;
    reg [31:0] adc_trigger_select_lo_reg;
    reg [11:0] int_status_reg;
    reg [11:0] int_mask_reg;
    reg unlock_reg;

    // Edge detector history
    reg [5:0] level_prev_reg;
    reg [5:0] edge_prev_reg;
    reg [3:0] hit_prev_reg;

    // Next-state and read-path values from the combinational blocks
    reg [5:0] level_brake_flag_next;
    reg [5:0] edge_brake_flag_next;
    reg [11:0] int_status_next;
    reg [31:0] rdata_next;
    reg err_next;

    // Combinational nets
    wire [11:0] brake_sync;
    wire [5:0] level_rise;
    wire [5:0] edge_rise;
    wire [3:0] hit;
    wire [3:0] hit_pulse;
    wire [3:0] adc_trig_enable;
    wire [15:0] adc_trig_source;
    wire setup_phase;
    wire wr_en;
    wire wr_brake_flags;
    wire wr_trig_sel;
    wire wr_int_status;
    wire wr_int_mask;
    wire wr_lock;
    wire brake_clear_ok;
    wire [5:0] level_clear;
    wire [5:0] edge_clear;
    wire [11:0] status_clear;
    wire [11:0] status_set;
    wire [11:0] irq_pending;

    // Single-register decode, shared by the five write strobes
    function addr_is;
        input [11:0] addr;
        input [11:0] offset;
        begin
            addr_is = (addr == offset);
        end
    endfunction

    // Address decode for the error answer, given on reads and writes alike; the write strobes use addr_is
    function is_mapped;
        input [11:0] addr;
        begin
            is_mapped = (addr == `PATB_OFF_BRAKE_FLAGS) || (addr == `PATB_OFF_TRIG_SEL) ||
                (addr == `PATB_OFF_INT_STATUS) || (addr == `PATB_OFF_INT_MASK) ||
                (addr == `PATB_OFF_LOCK);
        end
    endfunction

    // Brake event lines come from pin-level logic outside this clock
    patb_sync2 #(
        .WIDTH(12)
    ) u_brake_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .d_async({level_brake_event, edge_brake_event}),
        .q_sync(brake_sync)
    );

    // An event is a rising edge so a held level sets the flag once
    assign level_rise = brake_sync[11:6] & ~level_prev_reg;
    assign edge_rise = brake_sync[5:0] & ~edge_prev_reg;

    // Slave answers in the first access cycle
    assign setup_phase = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_trig
            assign adc_trig_enable[gi] = adc_trigger_select_lo_reg[8*gi+7];
            assign adc_trig_source[4*gi+3:4*gi] = adc_trigger_select_lo_reg[8*gi+3:8*gi];
            // Channels 0,1 see pair 0/1 and channels 2,3 see pair 2/3
            patb_trig_sel u_sel (
                .enable(adc_trig_enable[gi]),
                .source(adc_trig_source[4*gi+3:4*gi]),
                .even_zero(zero_point[gi/2]),
                .even_period(period_point[gi/2]),
                .even_up_match(up_match[(gi/2)*2]),
                .even_down_match(down_match[(gi/2)*2]),
                .odd_up_match(up_match[(gi/2)*2+1]),
                .odd_down_match(down_match[(gi/2)*2+1]),
                .hit(hit[gi])
            );
        end
    endgenerate

    // Edge of each hit so a multi-cycle event still gives one pulse
    assign hit_pulse = hit & ~hit_prev_reg;

    // Per-register write strobes, each qualified by the completing access cycle
    assign wr_brake_flags = wr_en & addr_is(paddr, `PATB_OFF_BRAKE_FLAGS);
    assign wr_trig_sel = wr_en & addr_is(paddr, `PATB_OFF_TRIG_SEL);
    assign wr_int_status = wr_en & addr_is(paddr, `PATB_OFF_INT_STATUS);
    assign wr_int_mask = wr_en & addr_is(paddr, `PATB_OFF_INT_MASK);
    assign wr_lock = wr_en & addr_is(paddr, `PATB_OFF_LOCK);

    // Protected clear: a locked write is dropped quietly, with no bus error
    assign brake_clear_ok = wr_brake_flags & unlock_reg;

    // Write-one-to-clear masks, zero unless the matching write is taken
    assign level_clear = brake_clear_ok ?
        pwdata[`PATB_LEVEL_LSB+5:`PATB_LEVEL_LSB] : 6'h00;
    assign edge_clear = brake_clear_ok ?
        pwdata[`PATB_EDGE_LSB+5:`PATB_EDGE_LSB] : 6'h00;
    assign status_clear = wr_int_status ? pwdata[11:0] : 12'h000;

    // New brake events laid out as the interrupt status bits: level high, edge low
    assign status_set = {level_rise, edge_rise};

    // Level flags: an event in the same cycle as a clear wins, so none is lost
    always @*
    begin
        level_brake_flag_next = (level_brake_flag_reg & ~level_clear) | level_rise;
    end

    // Edge flags follow the same set-over-clear order
    always @*
    begin
        edge_brake_flag_next = (edge_brake_flag_reg & ~edge_clear) | edge_rise;
    end

    // Interrupt status mirrors the flags but is cleared without the unlock
    always @*
    begin
        int_status_next = (int_status_reg & ~status_clear) | status_set;
    end

    // Unmasked pending sources; taken from the next state so irq tracks status
    assign irq_pending = int_status_next & int_mask_reg;

    // Read mux and error answer, prepared during setup
    always @*
    begin
        rdata_next = 32'h00000000;
        err_next = 1'b0;
        case (paddr)
            `PATB_OFF_BRAKE_FLAGS: rdata_next = {18'h0, level_brake_flag_reg, 2'b00,
                edge_brake_flag_reg};
            `PATB_OFF_TRIG_SEL: rdata_next = adc_trigger_select_lo_reg;
            `PATB_OFF_INT_STATUS: rdata_next = {20'h00000, int_status_reg};
            `PATB_OFF_INT_MASK: rdata_next = {20'h00000, int_mask_reg};
            `PATB_OFF_LOCK: rdata_next = {31'h0, unlock_reg};
            default: err_next = 1'b1;
        endcase
        // Second guard on the map, so a new case arm cannot open a hole by accident
        if (!is_mapped(paddr))
        begin
            err_next = 1'b1;
        end
    end

    // APB handshake: pready rises one cycle after setup, for exactly one cycle
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= setup_phase;
            pslverr <= setup_phase & err_next;
        end
    end

    // Read data register, loaded in step with pready
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h00000000;
        end
        else if (clk_en)
        begin
            // Read data is zero outside its own cycle, so stale values never leak
            prdata <= (setup_phase && !pwrite) ? rdata_next : 32'h00000000;
        end
    end

    // Brake flags, one bit per channel and detector kind
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_brake_flag_reg <= 6'h00;
            edge_brake_flag_reg <= 6'h00;
        end
        else if (clk_en)
        begin
            level_brake_flag_reg <= level_brake_flag_next;
            edge_brake_flag_reg <= edge_brake_flag_next;
        end
    end

    // Interrupt status, sticky until written with ones
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_status_reg <= 12'h000;
        end
        else if (clk_en)
        begin
            int_status_reg <= int_status_next;
        end
    end

    // Previous synchronised levels for the brake edge detectors
    // Reset to the idle low level so release of reset shows no false event
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_prev_reg <= 6'h00;
            edge_prev_reg <= 6'h00;
        end
        else if (clk_en)
        begin
            level_prev_reg <= brake_sync[11:6];
            edge_prev_reg <= brake_sync[5:0];
        end
    end

    // Trigger select register; reserved bits are not stored and read as zero
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adc_trigger_select_lo_reg <= `PATB_TRIG_SEL_RESET;
        end
        else if (clk_en && wr_trig_sel)
        begin
            adc_trigger_select_lo_reg <= pwdata & `PATB_TRIG_SEL_MASK;
        end
    end

    // Interrupt mask, one bit per status bit
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_mask_reg <= 12'h000;
        end
        else if (clk_en && wr_int_mask)
        begin
            int_mask_reg <= pwdata[11:0];
        end
    end

    // Lock: the key opens it and any other value closes it again, so a stray
    // write cannot leave the flags exposed
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unlock_reg <= 1'b0;
        end
        else if (clk_en && wr_lock)
        begin
            unlock_reg <= (pwdata == `PATB_UNLOCK_KEY);
        end
    end

    // Hit history: a selected event held high for several cycles gives one pulse
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hit_prev_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            hit_prev_reg <= hit;
        end
    end

    // ADC start: one cycle wide, channels merged, so two hits at once start once
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adc_trigger <= 1'b0;
        end
        else if (clk_en)
        begin
            adc_trigger <= |hit_pulse;
        end
    end

    // Level interrupt, registered so the output comes straight from a flop
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            irq <= |irq_pending;
        end
    end
endmodule // patb_top

// ---- sim/patb_checker.sv ----
// Concurrent checks on the ports of the trigger and brake flag block
module patb_checker (
    input wire core_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [5:0] level_brake_event,
    input wire [5:0] edge_brake_event,
    input wire [1:0] zero_point,
    input wire [1:0] period_point,
    input wire [3:0] up_match,
    input wire [3:0] down_match,
    input wire adc_trigger,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Counter events, brake inputs and taken writes as the causes of output moves
    wire [11:0] cev = {zero_point, period_point, up_match, down_match};
    wire [11:0] bev = {level_brake_event, edge_brake_event};
    wire wr = psel && penable && pwrite;
    a_setup_answer: assert property (psel && !penable |=> pready) else $error("no ready");
    a_ready_once: assert property (pready |=> !pready) else $error("ready held");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("data leak");
    a_hole_error: assert property (psel && !penable && paddr == 12'h0FC |=> pslverr)
        else $error("hole taken");
    a_trig_cause: assert property (adc_trigger |-> $past(cev) != 12'h0)
        else $error("trigger without event");
    // A held event must not give a second pulse
    a_trig_pulse: assert property (adc_trigger && $stable(cev) |=> !adc_trigger)
        else $error("trigger too long");
    a_irq_rise: assert property ($rose(irq) |-> $past(bev, 3) != 12'h0
        || $past(bev, 4) != 12'h0 || $past(wr) || $past(wr, 2)) else $error("irq rose");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
        else $error("irq fell");
endmodule // patb_checker

bind patb_top patb_checker i_patb_checker (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .level_brake_event(level_brake_event),
    .edge_brake_event(edge_brake_event), .zero_point(zero_point), .period_point(period_point),
    .up_match(up_match), .down_match(down_match), .adc_trigger(adc_trigger), .irq(irq));

// ---- sim/patb_adc_model.sv ----
// ADC start input model that counts conversion triggers
module patb_adc_model (
    input wire core_clk,
    input wire rst_n,
    input wire adc_trigger,
    output int starts
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each high sample starts one conversion, so a stretched pulse shows as extra starts
    always @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            starts <= 0;
        else if (adc_trigger)
            starts <= starts + 1;
endmodule // patb_adc_model

// ---- sim/patb_tb.sv ----
// Self-checking bench for trigger selection, brake flags and interrupt
`include "patb_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, clk_en = 1, er;
    logic pready, pslverr, adc_trigger, irq;
    logic [11:0] paddr = 12'h0, ev = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0] lvl = 6'h0, edg = 6'h0;
    int bad_count = 0, cmp_count = 0, starts;
    always #20 core_clk = ~core_clk;
    patb_top i_patb_top (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .level_brake_event(lvl), .edge_brake_event(edg),
        .zero_point(ev[1:0]), .period_point(ev[3:2]), .up_match(ev[7:4]),
        .down_match(ev[11:8]), .adc_trigger(adc_trigger), .irq(irq));
    patb_adc_model i_patb_adc_model (.core_clk(core_clk), .rst_n(rst_n),
        .adc_trigger(adc_trigger), .starts(starts));
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // One transfer; the request holds until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 20)
        begin
            bad_count++;
            end_of_test;
        end
    endtask
    task automatic t_regs;
        apb(1'b0, `PATB_OFF_TRIG_SEL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PATB_OFF_BRAKE_FLAGS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `PATB_OFF_TRIG_SEL, 32'hFFFFFFFF);
        apb(1'b0, `PATB_OFF_TRIG_SEL, 32'h0);
        chk(rd, 32'h8F8F8F8F);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        $display("register test done");
    endtask
    // Every defined code on every channel; event bit offset grows with the channel pair
    task automatic t_trig;
        int cd[10] = '{0, 1, 2, 2, 3, 4, 8, 9, 0, 0};
        int bs[10] = '{0, 2, 0, 2, 4, 8, 5, 9, 2, 0};
        int b;
        for (int ch = 0; ch < 4; ch++)
            for (int i = 0; i < 10; i++)
            begin
                b = bs[i] + (bs[i] < 4 ? ch / 2 : 2 * (ch / 2));
                apb(1'b1, `PATB_OFF_TRIG_SEL, {24'h0, i < 9, 3'h0, cd[i][3:0]} << (8 * ch));
                @(posedge core_clk);
                ev[b] <= 1'b1;
                @(posedge core_clk);
                ev[b] <= 1'b0;
                @(negedge core_clk);
                chk({31'h0, adc_trigger}, {31'h0, i < 8});
            end
        chk(starts, 32'h00000020);
        $display("trigger test done");
    endtask
    // Frozen clock enable: a selected event must not reach the ADC or the count
    task automatic t_freeze;
        int s;
        apb(1'b1, `PATB_OFF_TRIG_SEL, 32'h00000080);
        s = starts;
        @(posedge core_clk);
        clk_en <= 1'b0;
        ev[0] <= 1'b1;
        @(posedge core_clk);
        ev[0] <= 1'b0;
        repeat (2) @(posedge core_clk);
        clk_en <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk({31'h0, adc_trigger}, 32'h0);
        chk(starts - s, 32'h0);
        $display("freeze test done");
    endtask
    // Flags set while masked, a clear refused while locked, then taken
    task automatic t_brake;
        @(posedge core_clk);
        edg <= 6'h2D;
        lvl <= 6'h12;
        repeat (6) @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, `PATB_OFF_INT_STATUS, 32'h0);
        chk(rd, 32'h000004AD);
        apb(1'b1, `PATB_OFF_INT_MASK, 32'h00000FFF);
        repeat (2) @(negedge core_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `PATB_OFF_BRAKE_FLAGS, 32'h00003F3F);
        apb(1'b0, `PATB_OFF_BRAKE_FLAGS, 32'h0);
        chk(rd, 32'h0000122D);
        apb(1'b1, `PATB_OFF_LOCK, `PATB_UNLOCK_KEY);
        apb(1'b1, `PATB_OFF_BRAKE_FLAGS, 32'h00003F3F);
        apb(1'b0, `PATB_OFF_BRAKE_FLAGS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `PATB_OFF_INT_STATUS, 32'h00000FFF);
        repeat (2) @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
        $display("brake test done");
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs;
        t_trig;
        t_freeze;
        t_brake;
        end_of_test;
    end
endmodule // testbench
